// *** design/csoc_clock_synth_output_config.sv ***
// Register file and output steering for the clock synthesiser and auxiliary clock outputs.
// Overview of operation
// - Oscillator bias register resets to 0x4F, not the recommended operating value.
// - One four-bit pre-emphasis value drives every serializer lane together.
// - Trigger-output enable bit 7 turns the trigger buffer and divider off or on.
// - Trigger select: 0,1,2 give 16/32/64 UI clocks, 3 timestamp, 4-7 reserved.
// - Trigger clocks come from the serializer and drop during its re-initialisation.
// - Override bit 7 chooses configuration pins or register fields for the synthesiser.
// - Under override, bits 5:4 set the second divided-reference output: off, /1, /2, /4.
// - Under override, bits 3:2 set the first divided-reference output: off, /1, /2, /4.
// - Second divided-reference output runs only while the first one is running.
// - Under override, bit 1 selects the single-ended reference input instead of the pin.
// - Under override, bit 0 enables the synthesiser instead of its enable pin.
`timescale 1ns/1ns
module csoc_clock_synth_output_config
  import csoc_pkg::*;
(
  input  wire logic                  clk_in,
  input  wire logic                  rst_n_in,
  input  wire csoc_reg_req_t         reg_req_in,
  input  wire logic [2:0]            ser_ui_clock_in,
  input  wire logic                  ser_reinit_in,
  input  wire logic                  timestamp_input_in,
  input  wire logic                  pll_ref_in,
  input  wire logic                  synth_enable_pin_in,
  input  wire logic                  ref_select_pin_in,
  input  wire logic                  clock_config_pin_0_in,
  input  wire logic                  clock_config_pin_1_in,
  output logic [7:0]                 rd_data_out,
  output logic                       rd_valid_out,
  output logic [6:0]                 oscillator_bias_out,
  output logic [LANES-1:0][3:0]      lane_preemphasis_out,
  output logic                       trigger_output_enable_out,
  output logic                       trigger_output_out,
  output logic                       first_refdiv_output_out,
  output logic                       second_refdiv_output_out,
  output logic                       synth_enable_out,
  output logic                       single_ended_ref_select_out
);

  csoc_state_t      s;
  csoc_state_t      next_s;
  logic             ovr_en;
  csoc_refdiv_sel_t first_sel;
  csoc_refdiv_sel_t second_sel;

  function automatic logic refdiv(input csoc_refdiv_sel_t sel, input logic ref_lvl,
                                  input logic [1:0] cnt);
    unique case (sel)
      REFDIV_OFF: refdiv = 1'b0;
      REFDIV_1:   refdiv = ref_lvl;
      REFDIV_2:   refdiv = cnt[0];
      REFDIV_4:   refdiv = cnt[1];
    endcase
  endfunction : refdiv

  // Pin mode has no field for the second output, so it stays off there.
  always_comb begin
    ovr_en = s.override_ctrl[OVR_EN_BIT];
    if (ovr_en) begin
      first_sel  = csoc_refdiv_sel_t'(s.override_ctrl[FIRST_LSB+:2]);
      second_sel = csoc_refdiv_sel_t'(s.override_ctrl[SECOND_LSB+:2]);
    end else begin
      first_sel  = csoc_refdiv_sel_t'({clock_config_pin_1_in, clock_config_pin_0_in});
      second_sel = REFDIV_OFF;
    end
  end

  always_comb begin
    next_s          = s;
    next_s.rd_valid = reg_req_in.read;
    next_s.rd_data  = 8'h00;
    if (reg_req_in.read) begin
      unique case (reg_req_in.addr)
        OFF_OSC_BIAS:  next_s.rd_data = s.osc_bias_ctrl;
        OFF_PREEMPH:   next_s.rd_data = s.preemph_ctrl;
        OFF_TRIG_CTRL: next_s.rd_data = s.trig_ctrl;
        OFF_OVERRIDE:  next_s.rd_data = s.override_ctrl;
        default:       next_s.rd_data = 8'h00;
      endcase
    end
    if (reg_req_in.write) begin
      unique case (reg_req_in.addr)
        OFF_OSC_BIAS:  next_s.osc_bias_ctrl = reg_req_in.wdata;
        OFF_PREEMPH:   next_s.preemph_ctrl  = reg_req_in.wdata;
        OFF_TRIG_CTRL: next_s.trig_ctrl     = reg_req_in.wdata;
        OFF_OVERRIDE:  next_s.override_ctrl = reg_req_in.wdata;
        default:       next_s.rd_valid      = next_s.rd_valid;
      endcase
    end
    for (int i = 0; i < LANES; i++) begin
      next_s.lane_pe[i] = s.preemph_ctrl[PE_MSB:0];
    end
    // Divided reference is built from edges of the sampled reference level.
    next_s.ref_q = pll_ref_in;
    if (pll_ref_in && !s.ref_q) begin
      next_s.ref_cnt = s.ref_cnt + 2'h1;
    end
    next_s.first_out  = refdiv(first_sel, s.ref_q, s.ref_cnt);
    // The second output is gated by the first so it cannot run alone.
    next_s.second_out = (first_sel != REFDIV_OFF) &&
                        refdiv(second_sel, s.ref_q, s.ref_cnt);
    next_s.synth_en   = ovr_en ? s.override_ctrl[SYNTH_EN_BIT] : synth_enable_pin_in;
    next_s.se_ref_sel = ovr_en ? s.override_ctrl[SE_REF_BIT] : ref_select_pin_in;
    next_s.trig_en    = s.trig_ctrl[TRIG_EN_BIT];
    next_s.trig_out   = 1'b0;
    if (s.trig_ctrl[TRIG_EN_BIT]) begin
      unique case (s.trig_ctrl[TRIG_SEL_MSB:0])
        TRIG_UI16:      next_s.trig_out = ser_ui_clock_in[0] && !ser_reinit_in;
        TRIG_UI32:      next_s.trig_out = ser_ui_clock_in[1] && !ser_reinit_in;
        TRIG_UI64:      next_s.trig_out = ser_ui_clock_in[2] && !ser_reinit_in;
        TRIG_TIMESTAMP: next_s.trig_out = timestamp_input_in;
        default:        next_s.trig_out = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s               <= '0;
      s.osc_bias_ctrl <= RST_OSC_BIAS;
      s.preemph_ctrl  <= RST_PREEMPH;
      s.trig_ctrl     <= RST_TRIG_CTRL;
      s.override_ctrl <= RST_OVERRIDE;
    end else begin
      s <= next_s;
    end
  end

  assign rd_data_out                 = s.rd_data;
  assign rd_valid_out                = s.rd_valid;
  assign oscillator_bias_out         = s.osc_bias_ctrl[BIAS_MSB:0];
  assign lane_preemphasis_out        = s.lane_pe;
  assign trigger_output_enable_out   = s.trig_en;
  assign trigger_output_out          = s.trig_out;
  assign first_refdiv_output_out     = s.first_out;
  assign second_refdiv_output_out    = s.second_out;
  assign synth_enable_out            = s.synth_en;
  assign single_ended_ref_select_out = s.se_ref_sel;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  bias_write_a: assert property (
    reg_req_in.write && reg_req_in.addr == OFF_OSC_BIAS
    |=> oscillator_bias_out == $past(reg_req_in.wdata[BIAS_MSB:0]))
    else $error("Bias field did not take the written value.");
  lanes_common_a: assert property (
    reg_req_in.write && reg_req_in.addr == OFF_PREEMPH
    |=> ##1 (lane_preemphasis_out == {LANES{$past(reg_req_in.wdata[PE_MSB:0], 2)}}))
    else $error("Lanes do not share the written pre-emphasis.");
  trig_off_a: assert property (
    !s.trig_ctrl[TRIG_EN_BIT] |=> !trigger_output_out && !trigger_output_enable_out)
    else $error("Trigger output active while disabled.");
  trig_on_a: assert property (
    s.trig_ctrl[TRIG_EN_BIT] |=> trigger_output_enable_out)
    else $error("Trigger buffer not enabled.");
  trig_stamp_a: assert property (
    s.trig_ctrl[TRIG_EN_BIT] && s.trig_ctrl[TRIG_SEL_MSB:0] == TRIG_TIMESTAMP
    |=> trigger_output_out == $past(timestamp_input_in))
    else $error("Timestamp mode does not follow the timestamp input.");
  trig_reinit_a: assert property (
    s.trig_ctrl[TRIG_EN_BIT] && s.trig_ctrl[TRIG_SEL_MSB:0] <= TRIG_UI64 && ser_reinit_in
    |=> !trigger_output_out)
    else $error("Trigger clock ran during serializer re-initialisation.");
  second_gated_a: assert property (
    first_sel == REFDIV_OFF |=> !second_refdiv_output_out)
    else $error("Second divided output ran without the first.");
  synth_src_a: assert property (
    synth_enable_out == $past(ovr_en ? s.override_ctrl[SYNTH_EN_BIT] : synth_enable_pin_in))
    else $error("Synthesiser enable from the wrong source.");
  se_src_a: assert property (
    ovr_en |=> single_ended_ref_select_out == $past(s.override_ctrl[SE_REF_BIT]))
    else $error("Reference select ignores the override value.");
  first_div1_a: assert property (
    ovr_en && s.override_ctrl[FIRST_LSB+:2] == REFDIV_1 |=> first_refdiv_output_out == $past(s.ref_q))
    else $error("First divided output not passing the reference.");

endmodule : csoc_clock_synth_output_config

// *** design/csoc_pkg.sv ***
// Register map, field layout and shared types of the clock synthesiser output control block.
package csoc_pkg;

  localparam int         LANES         = 8;
  localparam int         ADDR_W        = 8;

  localparam logic [7:0] OFF_OSC_BIAS  = 8'h3F;
  localparam logic [7:0] OFF_PREEMPH   = 8'h48;
  localparam logic [7:0] OFF_TRIG_CTRL = 8'h57;
  localparam logic [7:0] OFF_OVERRIDE  = 8'h58;

  localparam logic [7:0] RST_OSC_BIAS  = 8'h4F;
  localparam logic [7:0] RST_PREEMPH   = 8'h00;
  localparam logic [7:0] RST_TRIG_CTRL = 8'h00;
  localparam logic [7:0] RST_OVERRIDE  = 8'h00;
  localparam logic [6:0] BIAS_RECOMMEND = 7'h4A;

  localparam int         BIAS_MSB      = 6;
  localparam int         PE_MSB        = 3;
  localparam int         TRIG_EN_BIT   = 7;
  localparam int         TRIG_SEL_MSB  = 2;
  localparam int         OVR_EN_BIT    = 7;
  localparam int         SECOND_LSB    = 4;
  localparam int         FIRST_LSB     = 2;
  localparam int         SE_REF_BIT    = 1;
  localparam int         SYNTH_EN_BIT  = 0;

  typedef enum logic [2:0] {
    TRIG_UI16      = 3'h0,
    TRIG_UI32      = 3'h1,
    TRIG_UI64      = 3'h2,
    TRIG_TIMESTAMP = 3'h3
  } csoc_trig_sel_t;

  typedef enum logic [1:0] {
    REFDIV_OFF = 2'h0,
    REFDIV_1   = 2'h1,
    REFDIV_2   = 2'h2,
    REFDIV_4   = 2'h3
  } csoc_refdiv_sel_t;

  typedef struct packed {
    logic       write;
    logic       read;
    logic [7:0] addr;
    logic [7:0] wdata;
  } csoc_reg_req_t;

  typedef struct packed {
    logic [7:0]            osc_bias_ctrl;
    logic [7:0]            preemph_ctrl;
    logic [7:0]            trig_ctrl;
    logic [7:0]            override_ctrl;
    logic [7:0]            rd_data;
    logic                  rd_valid;
    logic [LANES-1:0][3:0] lane_pe;
    logic                  ref_q;
    logic [1:0]            ref_cnt;
    logic                  first_out;
    logic                  second_out;
    logic                  trig_out;
    logic                  trig_en;
    logic                  synth_en;
    logic                  se_ref_sel;
  } csoc_state_t;

endpackage : csoc_pkg

// *** tb/csoc_testbench.sv ***
// Self-checking bench for the clock synthesiser output control block.
`timescale 1ns/1ns
module testbench;
  import csoc_pkg::*;
  localparam logic [7:0] TC [4] = '{8'h00, 8'h10, 8'h08, 8'h04};
  logic                  clk_in   = 1'b0;
  logic                  rst_n_in = 1'b0;
  csoc_reg_req_t         req      = '0;
  logic [2:0]            ui       = 3'h0;
  logic                  reinit   = 1'b0;
  logic                  ts       = 1'b0;
  logic                  pll_ref  = 1'b0;
  logic                  en_pin   = 1'b0;
  logic                  sel_pin  = 1'b0;
  logic [1:0]            cfg      = 2'h0;
  logic [7:0]            rd_data;
  logic                  rd_valid;
  logic [6:0]            bias;
  logic [LANES-1:0][3:0] lanes;
  logic                  trig_en, trig, first_o, second_o, synth_en, se_sel;
  int                    err_total = 0;
  int                    n_tests   = 0;
  int                    n1, n2;

  csoc_clock_synth_output_config csoc_clock_synth_output_config_i (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .reg_req_in(req), .ser_ui_clock_in(ui),
    .ser_reinit_in(reinit), .timestamp_input_in(ts), .pll_ref_in(pll_ref),
    .synth_enable_pin_in(en_pin), .ref_select_pin_in(sel_pin),
    .clock_config_pin_0_in(cfg[0]), .clock_config_pin_1_in(cfg[1]),
    .rd_data_out(rd_data), .rd_valid_out(rd_valid), .oscillator_bias_out(bias),
    .lane_preemphasis_out(lanes), .trigger_output_enable_out(trig_en),
    .trigger_output_out(trig), .first_refdiv_output_out(first_o),
    .second_refdiv_output_out(second_o), .synth_enable_out(synth_en),
    .single_ended_ref_select_out(se_sel));

  always #20 clk_in = ~clk_in;
  // The reference runs at a quarter of the clock so every divide ratio is countable.
  always begin
    repeat (2) @(negedge clk_in);
    pll_ref = ~pll_ref;
  end

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    req = '{1'b1, 1'b0, a, d};
    @(negedge clk_in);
    req = '0;
    repeat (3) @(negedge clk_in);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk_in);
    req = '{1'b0, 1'b1, a, 8'h00};
    @(negedge clk_in);
    req = '0;
    chk("rd_valid", {7'h0, rd_valid}, 8'h01);
    chk("rd_data", rd_data, exp);
  endtask : rd

  // Settles past any mode-switch glitch, then counts edges over whole periods.
  task automatic meas(output int c1, output int c2);
    logic p1, p2;
    c1 = 0;
    c2 = 0;
    repeat (8) @(negedge clk_in);
    p1 = first_o;
    p2 = second_o;
    repeat (32) begin
      @(negedge clk_in);
      c1 += int'(first_o !== p1);
      c2 += int'(second_o !== p2);
      p1 = first_o;
      p2 = second_o;
    end
  endtask : meas

  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test

  initial begin
    #2000000;
    err_total++;
    finish_test();
  end

  initial begin
    logic [7:0] rows [5][3];
    logic       e;
    // Reserved bits of mapped registers are written as zero, their reset value.
    rows = '{'{8'h57, 8'h03, 8'h03}, '{8'h58, 8'h3C, 8'h3C}, '{8'h40, 8'hFF, 8'h00},
             '{8'h48, 8'h05, 8'h05}, '{8'h3F, 8'h4A, 8'h4A}};
    repeat (3) @(negedge clk_in);
    chk("bias in reset", {1'b0, bias}, 8'h4F);
    rst_n_in = 1'b1;
    rd(OFF_OSC_BIAS, RST_OSC_BIAS);
    rd(OFF_PREEMPH, 8'h00);
    rd(OFF_TRIG_CTRL, 8'h00);
    rd(OFF_OVERRIDE, 8'h00);
    // The synthesiser reset bit lives outside this block, so these writes are ignored here.
    wr(8'h5C, 8'h01);
    for (int r = 0; r < 5; r++) begin
      wr(rows[r][0], rows[r][1]);
      rd(rows[r][0], rows[r][2]);
    end
    wr(8'h5C, 8'h00);
    chk("bias", {1'b0, bias}, 8'h4A);
    for (int i = 0; i < LANES; i++) chk("lane", {4'h0, lanes[i]}, 8'h05);
    for (int s = 0; s < 8; s++) begin
      wr(8'h57, 8'(s));
      wr(8'h57, 8'h80 | 8'(s));
      chk("trig_en", {7'h0, trig_en}, 8'h01);
      for (int k = 0; k < 2; k++) begin
        ui = k[0] ? 3'h2 : 3'h5;
        ts = ~k[0];
        e = (s < 3) ? ui[s] : (s == 3) ? ts : 1'b0;
        repeat (3) @(negedge clk_in);
        chk("trig", {7'h0, trig}, {7'h0, e});
      end
      ui = 3'h7;
      ts = 1'b1;
      reinit = 1'b1;
      repeat (3) @(negedge clk_in);
      chk("trig reinit", {7'h0, trig}, {7'h0, s == 3});
      reinit = 1'b0;
      // Clear the enable first so the next select change happens while it is off.
      wr(8'h57, 8'(s));
    end
    wr(8'h57, 8'h03);
    chk("trig off", {6'h0, trig_en, trig}, 8'h00);
    en_pin = 1'b1;
    sel_pin = 1'b1;
    cfg = 2'h3;
    wr(8'h58, 8'h30);
    meas(n1, n2);
    chk("pin first", 8'(n1), 8'h04);
    chk("pin second", 8'(n2), 8'h00);
    chk("pin en sel", {6'h0, synth_en, se_sel}, 8'h03);
    en_pin = 1'b0;
    sel_pin = 1'b0;
    for (int c = 0; c < 4; c++) begin
      for (int d = 0; d < 4; d++) begin
        wr(8'h58, {2'b10, 2'(d), 2'(c), d[0], c[0]});
        meas(n1, n2);
        chk("first", 8'(n1), TC[c]);
        chk("second", 8'(n2), (c == 0) ? 8'h00 : TC[d]);
        chk("synth_en", {7'h0, synth_en}, {7'h0, c[0]});
        chk("se_sel", {7'h0, se_sel}, {7'h0, d[0]});
      end
    end
    rst_n_in = 1'b0;
    repeat (3) @(negedge clk_in);
    chk("bias rearm", {1'b0, bias}, 8'h4F);
    rst_n_in = 1'b1;
    rd(OFF_OVERRIDE, 8'h00);
    finish_test();
  end
endmodule : testbench
